// ==== inc/lepr_defs.svh ====
/*
 * offsets, reset values and timing counts of the link event and parameter registers.
 * assumes a byte-wide host bus with a 6-bit address.
 */
`ifndef LEPR_DEFS_SVH
`define LEPR_DEFS_SVH
// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define LEPR_ADR_RDATA0 6'h05
`define LEPR_ADR_RDATA2 6'h07
`define LEPR_ADR_EVENT 6'h08
`define LEPR_ADR_PRM0 6'h10
`define LEPR_PRM_LAST 16
`define LEPR_RST_PRM 8'h00
// ---------------------------------------------------------------
// fields and counts
// ---------------------------------------------------------------
`define LEPR_CODE_MAX 5'h1b
`define LEPR_FIFO_DEPTH 8
`define LEPR_TIMER_SCALE_NS 327680
`define LEPR_CLK_NS 10
`endif

// ==== inc/lepr_pkg.sv ====
/*
 * types of the link event and parameter registers.
 * assumes lepr_defs.svh sits on the include path.
 */
package lepr_pkg;
    typedef enum logic [2:0] {RX_NONE, RX_SABM, RX_UA, RX_DM, RX_FRMR, RX_DISC} lepr_rx_frame_t;
    typedef enum logic [1:0] {HPE_IDLE, HPE_RETRY} lepr_hpe_state_t;
endpackage : lepr_pkg

// ==== test/lepr_host.sv ====
/*
 * host processor model on the byte-wide register bus.
 * assumes the registers sample strobes at the rising clock edge.
 */
module lepr_host (
    // clock
    input wire logic clk_i,
    // register bus
    output logic rd_o,
    output logic wr_o,
    output logic [5:0] addr_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // bus cycles
    // ---------------------------------------------------------------
    // released lines show the inverse of their last value, never a held copy
    initial
    begin
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 6'h00;
        data_o = 8'h00;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        data_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        data_o <= ~d;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
    endtask : rd
endmodule : lepr_host

// ==== test/lepr_regs_tb.sv ====
/*
 * self-checking bench of the link event and parameter registers.
 * assumes lepr_host drives the bus; timers run with TIMER_SCALE cut to 4.
 */
`include "lepr_defs.svh"
module lepr_regs_tb
    import lepr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // stimulus and dut
    // ---------------------------------------------------------------
    localparam logic [5:0] EV = `LEPR_ADR_EVENT;
    localparam logic [4:0] CODES [12] = '{5'h07, 5'h08, 5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h10,
        5'h11, 5'h12, 5'h13, 5'h14, 5'h1b};
    // reserved bits are kept clear by the host
    localparam logic [7:0] MASK [17] = '{8'h07, 8'h37, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h0f, 8'hff, 8'h1f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff};
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic rd, wr, oe, retx, busy, clr_s, clr_r, nle, fle, echo, idle_bf, pwx;
    logic info = 1'b0, disc = 1'b0, monitor_disconnect = 1'b0, xwait = 1'b0, send = 1'b0, rdy = 1'b1;
    logic dma_tx = 1'b1, cts_n = 1'b0, cd_n = 1'b1, parity = 1'b0;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, cfa, rfa, mflg;
    lepr_rx_frame_t frame_in = RX_NONE;
    logic [23:0] frmr = 24'h0;
    logic [15:0] pulse = 16'h0, tbl;
    logic [3:0] t_run = 4'h0, t_exp, retry;
    logic [2:0] win;
    logic [12:0] mrx;
    logic [7:0] exp_q [$];
    logic [7:0] p [17];
    int n_fail = 0, checked = 0, cycles = 0, n_cs = 0, n_cr = 0, n;
    lepr_host u_host (.clk_i(sys_clk_i), .rd_o(rd), .wr_o(wr), .addr_o(addr), .data_o(wdata));
    lepr_regs #(.TIMER_SCALE(4)) u_dut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .bus_rd_i(rd), .bus_wr_i(wr),
        .bus_addr_i(addr), .bus_data_i(wdata), .bus_data_o(rdata), .bus_data_oe_o(oe),
        .info_transfer_i(info), .link_disconnected_i(disc), .monitor_disconnect_i(monitor_disconnect),
        .rx_frame_i(frame_in), .rx_frmr_data_i(frmr), .retry_limit_event_i(pulse[0]),
        .unsolicited_final_event_i(pulse[1]), .xid_received_event_i(pulse[2]),
        .xid_wait_i(xwait), .reject_sent_bad_control_i(pulse[3]),
        .reject_sent_bad_info_i(pulse[4]), .reject_sent_too_long_i(pulse[5]),
        .reject_sent_bad_nr_i(pulse[6]), .packet_received_event_i(pulse[7]),
        .tx_acknowledged_event_i(pulse[8]), .rx_overrun_event_i(pulse[9]),
        .tx_underrun_event_i(pulse[10]), .send_cmd_i(send), .rx_desc_check_i(pulse[12]),
        .rx_buffer_ready_flag_i(rdy), .busy_clear_i(pulse[13]), .tx_table_check_i(pulse[14]),
        .dma_attempt_i(pulse[15]), .dma_is_tx_i(dma_tx), .empty_iframe_event_i(pulse[11]),
        .timer_run_i(t_run), .cts_n_i(cts_n), .cd_n_i(cd_n), .parity_error_input_i(parity),
        .timer_expired_o(t_exp), .retransmit_o(retx), .station_busy_o(busy),
        .clear_send_o(clr_s), .clear_receiver_ready_cmd_o(clr_r),
        .near_loopback_enable_o(nle), .far_loopback_enable_o(fle), .echo_enable_o(echo),
        .window_size_o(win), .idle_between_frames_o(idle_bf),
        .password_exchange_enable_o(pwx), .tx_descriptor_table_o(tbl), .retry_limit_o(retry),
        .max_rx_length_o(mrx), .command_frame_address_o(cfa), .response_frame_address_o(rfa),
        .min_flags_o(mflg));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    // ---------------------------------------------------------------
    // checking
    // ---------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic check(input string s, input logic [15:0] seen, input logic [15:0] e);
        checked++;
        if (seen !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", s, e, seen);
        end
    endtask : check
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (clr_s === 1'b1)
            n_cs++;
        if (clr_r === 1'b1)
            n_cr++;
        if (oe === 1'b1)
            check("bus_data_o", rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        if (cycles == 20000)
            n_fail++;
        if (cycles == 20000)
            summarize();
    end
    task automatic rdx(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.rd(a);
    endtask : rdx
    task automatic fire(input logic [15:0] m);
        @(posedge sys_clk_i);
        pulse <= m;
        @(posedge sys_clk_i);
        pulse <= 16'h0;
        repeat (6) @(posedge sys_clk_i);
    endtask : fire
    task automatic frame(input lepr_rx_frame_t f, input logic [4:0] c);
        @(posedge sys_clk_i);
        frame_in <= f;
        // a received frame lasts one cycle, or it would be queued again
        @(posedge sys_clk_i);
        frame_in <= RX_NONE;
        repeat (6) @(posedge sys_clk_i);
        rdx(EV, {3'h0, c});
    endtask : frame
    task automatic wt(input int b);
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end
        while (t_exp[b] !== 1'b1 && n < 200);
    endtask : wt
    initial
    begin
        void'($urandom(31));
        repeat (20) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        for (int k = 0; k < 17; k++)
            rdx(6'(`LEPR_ADR_PRM0 + k), 8'h00);
        rdx(EV, 8'h00);
        rdx(6'h3f, 8'h00);
        check("min_flags_o", mflg, 8'h01);
        for (int k = 0; k < 17; k++)
        begin
            p[k] = (8'($urandom) & MASK[k]) | (k == 1 ? 8'h11 : 8'h00);
            u_host.wr(6'(`LEPR_ADR_PRM0 + k), p[k]);
        end
        for (int k = 0; k < 17; k++)
            rdx(6'(`LEPR_ADR_PRM0 + k), p[k]);
        check("loop_bits", {nle, fle, echo}, {p[0][0], p[0][1], p[0][2]});
        check("window_size_o", {pwx, win}, {p[1][5], p[1][2:0]});
        check("max_rx_length_o", mrx, {p[9][4:0], p[8]});
        check("tx_descriptor_table_o", tbl, {p[3], p[2]});
        check("retry_limit_o", retry, p[5][7:4]);
        check("frame_addresses", {cfa, rfa}, {p[14], p[15]});
        check("min_flags_o", mflg, p[16] == 8'h00 ? 8'h01 : p[16]);
        for (int k = 0; k < 4; k++)
        begin
            disc <= k[0];
            monitor_disconnect <= k[1];
            @(posedge sys_clk_i);
            check("idle_between_frames_o", idle_bf, k[0] & ~k[1]);
        end
        $display("test parameters done");
        for (int i = 0; i < 12; i++)
        begin
            fire(16'(1 << i));
            rdx(EV, {3'h0, CODES[i]});
            rdx(EV, 8'h00);
        end
        fire(16'h01ff);
        fire(16'h0100);
        rdx(EV, 8'h87);
        rdx(EV, 8'h08);
        for (int i = 2; i < 9; i++)
            rdx(EV, {3'h0, CODES[i]});
        rdx(EV, 8'h00);
        $display("test event queue done");
        info <= 1'b1;
        frame(RX_NONE, 5'h09);
        frame(RX_SABM, 5'h01);
        frame(RX_UA, 5'h02);
        frame(RX_DISC, 5'h05);
        cts_n <= 1'b1;
        frame(RX_NONE, 5'h16);
        info <= 1'b0;
        cts_n <= 1'b0;
        frame(RX_NONE, 5'h0a);
        frame(RX_SABM, 5'h00);
        frame(RX_DM, 5'h03);
        frmr <= 24'($urandom);
        frame(RX_FRMR, 5'h04);
        for (int b = 0; b < 3; b++)
            rdx(6'(`LEPR_ADR_RDATA0 + b), frmr[8 * b +: 8]);
        cd_n <= 1'b0;
        frame(RX_NONE, 5'h17);
        cd_n <= 1'b1;
        frame(RX_NONE, 5'h18);
        $display("test frames and pins done");
        u_host.wr(6'h14, 8'h02);
        u_host.wr(6'h15, 8'h00);
        t_run <= 4'h1;
        wt(0);
        wt(0);
        check("t1_period", n, 16'd8);
        u_host.wr(6'h1a, 8'h01);
        u_host.wr(6'h1b, 8'h00);
        u_host.wr(6'h1c, 8'h01);
        u_host.wr(6'h1d, 8'h00);
        xwait <= 1'b1;
        t_run <= 4'h8;
        wt(3);
        t_run <= 4'h4;
        wt(2);
        check("t3_period", n, 16'd4);
        t_run <= 4'h0;
        xwait <= 1'b0;
        frame(RX_NONE, 5'h0c);
        rdx(EV, 8'h06);
        $display("test timers done");
        u_host.wr(6'h12, 8'h00);
        u_host.wr(6'h13, 8'h00);
        fire(16'h4000);
        rdx(EV, 8'h19);
        u_host.wr(6'h12, 8'h40);
        fire(16'h4000);
        rdx(EV, 8'h00);
        rdy <= 1'b0;
        fire(16'h1000);
        rdx(EV, 8'h15);
        check("station_busy_o", busy, 16'h1);
        fire(16'h2000);
        check("station_busy_o", busy, 16'h0);
        send <= 1'b1;
        parity <= 1'b1;
        fire(16'h0400);
        rdx(EV, 8'h14);
        check("retransmit_o", retx, 16'h1);
        send <= 1'b0;
        fire(16'h8000);
        fire(16'h8000);
        rdx(EV, 8'h1a);
        check("clear_send_count", 16'(n_cs), 16'h1);
        dma_tx <= 1'b0;
        fire(16'h8000);
        fire(16'h8000);
        rdx(EV, 8'h1a);
        check("clear_rx_ready_count", 16'(n_cr), 16'h1);
        check("retransmit_o", retx, 16'h0);
        $display("test side effects done");
        repeat (4) @(posedge sys_clk_i);
        check("pending_reads", 16'(exp_q.size()), 16'h0);
        summarize();
    end
endmodule : lepr_regs_tb

// ==== verilog/lepr_regs.sv ====
/*
 * event code queue, received reject data and parameter registers of a link controller.
 * assumes the host bus strobes and protocol engine events are on sys_clk; modem pins and
 * the parity pin are asynchronous and are synchronised here.
 */
`include "lepr_defs.svh"

// How it works
// - event code sits in bits 4:0, values 0 to 27, bits 6:5 read zero
// - bit 7 flags lost event codes, cleared by reading the register
// - code 0 reads when nothing is outstanding
// - SABM=1, UA=2, DISC=5 only in information transfer; DM=3 always
// - FRMR received raises 4 and keeps its three data bytes
// - T3 idle expiry raises 6; retry limit raises 7 (C2 or N2)
// - final bit response without our poll raises 8
// - entering information transfer raises 9, leaving raises 10
// - XID stored raises 11; no XID response within T4 raises 12
// - frame reject sent raises 13 to 16 by cause
// - I frame stored raises 17; acknowledgments processed raise 18
// - receive FIFO overrun raises 19
// - transmit underrun raises 20; retransmit while send command stays set
// - receive descriptor not ready raises 21 and enters station busy
// - CTS lost in transfer raises 22; carrier low 23, carrier high 24
// - zero transmit table start address raises 25
// - parity on both DMA attempts raises 26 and clears send or receiver ready
// - param 0: near loopback, far loopback, echo bits
// - param 1: window size bits 2:0, zero passed through as written; bit 5 password exchange
// - disconnected with monitor disconnect zero: bit 4 picks flags or idle
// - each timer with a nonzero 12-bit value has a period of 32768 clocks times that value
// - minimum interframe flags is the flag count, or one when zero
module lepr_regs
    import lepr_pkg::*;
#(
    parameter int TIMER_SCALE = `LEPR_TIMER_SCALE_NS / `LEPR_CLK_NS
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // host bus
    input wire logic bus_rd_i,
    input wire logic bus_wr_i,
    input wire logic [5:0] bus_addr_i,
    input wire logic [7:0] bus_data_i,
    output logic [7:0] bus_data_o,
    output logic bus_data_oe_o,
    // protocol engine events
    input wire logic info_transfer_i,
    input wire logic link_disconnected_i,
    input wire logic monitor_disconnect_i,
    input lepr_rx_frame_t rx_frame_i,
    input wire logic [23:0] rx_frmr_data_i,
    input wire logic retry_limit_event_i,
    input wire logic unsolicited_final_event_i,
    input wire logic xid_received_event_i,
    input wire logic xid_wait_i,
    input wire logic reject_sent_bad_control_i,
    input wire logic reject_sent_bad_info_i,
    input wire logic reject_sent_too_long_i,
    input wire logic reject_sent_bad_nr_i,
    input wire logic packet_received_event_i,
    input wire logic tx_acknowledged_event_i,
    input wire logic rx_overrun_event_i,
    input wire logic tx_underrun_event_i,
    input wire logic send_cmd_i,
    input wire logic rx_desc_check_i,
    input wire logic rx_buffer_ready_flag_i,
    input wire logic busy_clear_i,
    input wire logic tx_table_check_i,
    input wire logic dma_attempt_i,
    input wire logic dma_is_tx_i,
    input wire logic empty_iframe_event_i,
    input wire logic [3:0] timer_run_i,
    // asynchronous pins
    input wire logic cts_n_i,
    input wire logic cd_n_i,
    input wire logic parity_error_input_i,
    // results
    output logic [3:0] timer_expired_o,
    output logic retransmit_o,
    output logic station_busy_o,
    output logic clear_send_o,
    output logic clear_receiver_ready_cmd_o,
    // parameters
    output logic near_loopback_enable_o,
    output logic far_loopback_enable_o,
    output logic echo_enable_o,
    output logic [2:0] window_size_o,
    output logic idle_between_frames_o,
    output logic password_exchange_enable_o,
    output logic [15:0] tx_descriptor_table_o,
    output logic [3:0] retry_limit_o,
    output logic [12:0] max_rx_length_o,
    output logic [7:0] command_frame_address_o,
    output logic [7:0] response_frame_address_o,
    output logic [7:0] min_flags_o
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    logic [2:0] pin_old_reg;
    always_ff @(posedge sys_clk_i)
    begin
        pin_s1_reg <= {parity_error_input_i, cd_n_i, cts_n_i};
        pin_s2_reg <= pin_s1_reg;
        pin_old_reg <= pin_s2_reg;
    end
    wire logic cts_rise = pin_s2_reg[0] & ~pin_old_reg[0];
    wire logic cd_fall = ~pin_s2_reg[1] & pin_old_reg[1];
    wire logic cd_rise = pin_s2_reg[1] & ~pin_old_reg[1];
    wire logic parity_bad = pin_s2_reg[2];

    // ---------------------------------------------------------------
    // parameter registers
    // ---------------------------------------------------------------
    logic [7:0] prm_reg [0:`LEPR_PRM_LAST];
    wire logic [5:0] prm_idx = bus_addr_i - `LEPR_ADR_PRM0;
    wire logic prm_hit = (bus_addr_i >= `LEPR_ADR_PRM0) && (prm_idx <= 6'(`LEPR_PRM_LAST));
    always_ff @(posedge sys_clk_i)
    begin
        for (int i = 0; i <= `LEPR_PRM_LAST; i++)
        begin
            if (srst_i)
                prm_reg[i] <= `LEPR_RST_PRM;
            else if (bus_wr_i && prm_hit && prm_idx == 6'(i))
                prm_reg[i] <= bus_data_i;
        end
    end
    assign near_loopback_enable_o = prm_reg[0][0];
    assign far_loopback_enable_o = prm_reg[0][1];
    assign echo_enable_o = prm_reg[0][2];
    // zero window is the host's fault; it is passed through as written
    assign window_size_o = prm_reg[1][2:0];
    assign password_exchange_enable_o = prm_reg[1][5];
    // outside the disconnected, monitor-off case the engine keeps flagging
    assign idle_between_frames_o = link_disconnected_i & ~monitor_disconnect_i
        & prm_reg[1][4];
    assign tx_descriptor_table_o = {prm_reg[3], prm_reg[2]};
    assign retry_limit_o = prm_reg[5][7:4];
    assign max_rx_length_o = {prm_reg[9][4:0], prm_reg[8]};
    assign command_frame_address_o = prm_reg[14];
    assign response_frame_address_o = prm_reg[15];
    assign min_flags_o = (prm_reg[16] == 8'h00) ? 8'h01 : prm_reg[16];

    // ---------------------------------------------------------------
    // protocol timers
    // ---------------------------------------------------------------
    logic [11:0] tmr_value [0:3];
    assign tmr_value[0] = {prm_reg[5][3:0], prm_reg[4]};
    assign tmr_value[1] = {prm_reg[7][3:0], prm_reg[6]};
    assign tmr_value[2] = {prm_reg[13][3:0], prm_reg[12]};
    assign tmr_value[3] = {prm_reg[11][3:0], prm_reg[10]};
    generate
        for (genvar t = 0; t < 4; t++)
        begin : g_tmr
            logic [15:0] pre_reg;
            logic [11:0] ticks_reg;
            wire logic tick = (pre_reg == 16'(TIMER_SCALE - 1));
            // a zero value never expires rather than firing at once
            wire logic done = tick && tmr_value[t] != 12'h000
                && ticks_reg == tmr_value[t] - 12'h001;
            always_ff @(posedge sys_clk_i)
            begin
                if (srst_i || !timer_run_i[t] || done)
                begin
                    pre_reg <= 16'h0000;
                    ticks_reg <= 12'h000;
                end
                else
                begin
                    pre_reg <= tick ? 16'h0000 : pre_reg + 16'h0001;
                    ticks_reg <= tick ? ticks_reg + 12'h001 : ticks_reg;
                end
            end
            assign timer_expired_o[t] = done;
        end
    endgenerate

    // ---------------------------------------------------------------
    // event sources
    // ---------------------------------------------------------------
    logic info_old_reg;
    logic underrun_reg;
    logic busy_reg;
    logic [23:0] frmr_data_reg;
    lepr_hpe_state_t hpe_reg;
    always_ff @(posedge sys_clk_i)
    begin
        info_old_reg <= srst_i ? 1'b0 : info_transfer_i;
    end

    wire logic hpe_event = dma_attempt_i && parity_bad && hpe_reg == HPE_RETRY;
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            hpe_reg <= HPE_IDLE;
        else if (dma_attempt_i)
        begin
            case (hpe_reg)
                HPE_IDLE: hpe_reg <= parity_bad ? HPE_RETRY : HPE_IDLE;
                HPE_RETRY: hpe_reg <= HPE_IDLE;
                default: hpe_reg <= HPE_IDLE;
            endcase
        end
    end
    assign clear_send_o = hpe_event & dma_is_tx_i;
    assign clear_receiver_ready_cmd_o = hpe_event & ~dma_is_tx_i;

    wire logic desc_busy = rx_desc_check_i & ~rx_buffer_ready_flag_i;
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            underrun_reg <= 1'b0;
            busy_reg <= 1'b0;
            frmr_data_reg <= 24'h000000;
        end
        else
        begin
            // retries stop as soon as the host drops the send command
            underrun_reg <= (underrun_reg | tx_underrun_event_i) & send_cmd_i;
            busy_reg <= desc_busy | (busy_reg & ~busy_clear_i);
            if (rx_frame_i == RX_FRMR)
                frmr_data_reg <= rx_frmr_data_i;
        end
    end
    assign retransmit_o = underrun_reg;
    assign station_busy_o = busy_reg;

    logic [27:1] ev_raise;
    assign ev_raise[1] = rx_frame_i == RX_SABM && info_transfer_i;
    assign ev_raise[2] = rx_frame_i == RX_UA && info_transfer_i;
    assign ev_raise[3] = rx_frame_i == RX_DM;
    assign ev_raise[4] = rx_frame_i == RX_FRMR;
    assign ev_raise[5] = rx_frame_i == RX_DISC && info_transfer_i;
    assign ev_raise[6] = timer_expired_o[2];
    // software tells C2 from N2 by the password exchange state
    assign ev_raise[7] = retry_limit_event_i;
    assign ev_raise[8] = unsolicited_final_event_i;
    assign ev_raise[9] = info_transfer_i & ~info_old_reg;
    assign ev_raise[10] = ~info_transfer_i & info_old_reg;
    assign ev_raise[11] = xid_received_event_i;
    assign ev_raise[12] = timer_expired_o[3] & xid_wait_i;
    assign ev_raise[13] = reject_sent_bad_control_i;
    assign ev_raise[14] = reject_sent_bad_info_i;
    assign ev_raise[15] = reject_sent_too_long_i;
    assign ev_raise[16] = reject_sent_bad_nr_i;
    assign ev_raise[17] = packet_received_event_i;
    assign ev_raise[18] = tx_acknowledged_event_i;
    assign ev_raise[19] = rx_overrun_event_i;
    assign ev_raise[20] = tx_underrun_event_i;
    assign ev_raise[21] = desc_busy;
    assign ev_raise[22] = cts_rise & info_transfer_i;
    assign ev_raise[23] = cd_fall;
    assign ev_raise[24] = cd_rise;
    assign ev_raise[25] = tx_table_check_i && tx_descriptor_table_o == 16'h0000;
    assign ev_raise[26] = hpe_event;
    assign ev_raise[27] = empty_iframe_event_i;

    // ---------------------------------------------------------------
    // event queue
    // ---------------------------------------------------------------
    // one pending bit per code lets simultaneous events queue one per cycle;
    // a repeat of a code still pending is the only way an event is lost
    logic [27:1] pend_reg;
    logic [27:1] taken_vec;
    logic [4:0] fifo_mem [0:`LEPR_FIFO_DEPTH-1];
    logic [2:0] wr_ptr_reg;
    logic [2:0] rd_ptr_reg;
    logic [3:0] count_reg;
    logic lost_reg;
    logic [4:0] pick;
    always_comb
    begin
        pick = 5'h00;
        for (int i = 27; i >= 1; i--)
        begin
            if (pend_reg[i])
                pick = 5'(i);
        end
    end
    wire logic fifo_full = count_reg == 4'(`LEPR_FIFO_DEPTH);
    wire logic fifo_empty = count_reg == 4'h0;
    wire logic push = pick != 5'h00 && !fifo_full;
    wire logic event_rd = bus_rd_i && bus_addr_i == `LEPR_ADR_EVENT;
    wire logic pop = event_rd && !fifo_empty;
    wire logic [4:0] head = fifo_empty ? 5'h00 : fifo_mem[rd_ptr_reg];
    // a code raised again in the cycle it is queued stays pending, it is not lost
    wire logic lost_now = |(ev_raise & pend_reg & ~taken_vec);

    generate
        for (genvar c = 1; c <= 27; c++)
        begin : g_pend
            assign taken_vec[c] = push && pick == 5'(c);
            always_ff @(posedge sys_clk_i)
            begin
                if (srst_i)
                    pend_reg[c] <= 1'b0;
                else
                    pend_reg[c] <= ev_raise[c] | (pend_reg[c] & ~taken_vec[c]);
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i)
    begin
        if (push)
            fifo_mem[wr_ptr_reg] <= pick;
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            wr_ptr_reg <= 3'h0;
            rd_ptr_reg <= 3'h0;
            count_reg <= 4'h0;
            lost_reg <= 1'b0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg + 3'(push);
            rd_ptr_reg <= rd_ptr_reg + 3'(pop);
            count_reg <= count_reg + 4'(push) - 4'(pop);
            // a loss in the read cycle survives the clear
            lost_reg <= lost_now | (lost_reg & ~event_rd);
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    wire logic [7:0] event_word = {lost_reg, 2'b00, head};
    wire logic frmr_hit = bus_addr_i >= `LEPR_ADR_RDATA0 && bus_addr_i <= `LEPR_ADR_RDATA2;
    wire logic [4:0] frmr_sel = 5'((bus_addr_i - `LEPR_ADR_RDATA0) * 6'h08);
    wire logic [7:0] rd_mux = event_rd ? event_word
        : frmr_hit ? frmr_data_reg[frmr_sel +: 8]
        : prm_hit ? prm_reg[prm_idx[4:0]] : 8'h00;
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            bus_data_o <= 8'h00;
            bus_data_oe_o <= 1'b0;
        end
        else
        begin
            bus_data_o <= bus_rd_i ? rd_mux : bus_data_o;
            bus_data_oe_o <= bus_rd_i;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    a_code_range: assert property (head <= `LEPR_CODE_MAX)
        else $error("event code above 27");
    a_zero_bits: assert property (event_rd |=> bus_data_oe_o && bus_data_o[6:5] == 2'b00)
        else $error("event register bits 6:5 not zero");
    a_lost_clear: assert property (event_rd && !lost_now |=> !lost_reg)
        else $error("lost flag survived a read");
    a_lost_set: assert property (lost_now |=> lost_reg)
        else $error("lost flag not set");
    a_empty_null: assert property (event_rd && fifo_empty && pick == 5'h00 |=> bus_data_o[4:0] == 5'h00)
        else $error("empty queue did not read zero");
    a_dm_any: assert property (rx_frame_i == RX_DM |=> pend_reg[3])
        else $error("disconnected mode frame not queued");
    a_sabm_gate: assert property (rx_frame_i == RX_SABM && !info_transfer_i && !pend_reg[1] |=> !pend_reg[1])
        else $error("SABM queued outside information transfer");
    a_link_edge: assert property ($rose(info_transfer_i) |=> pend_reg[9])
        else $error("link up code missing");
    a_null_addr: assert property (tx_table_check_i && tx_descriptor_table_o == 16'h0000 |=> pend_reg[25])
        else $error("zero table address not reported");
    a_hpe_clear: assert property (dma_attempt_i && parity_bad && hpe_reg == HPE_RETRY |-> clear_send_o ^ clear_receiver_ready_cmd_o)
        else $error("hard parity did not clear a command bit");
    a_busy_enter: assert property (desc_busy |=> station_busy_o)
        else $error("station busy not entered");
    a_flag_min: assert property (min_flags_o != 8'h00)
        else $error("flag minimum is zero");
    a_pop_step: assert property (pop && !push |=> count_reg == $past(count_reg) - 4'h1)
        else $error("read did not pop the queue");

    c_fifo_full: cover property (fifo_full);
    c_lost: cover property (lost_now);
    c_pop: cover property (pop ##1 pop);
endmodule : lepr_regs
